// File: phy_aux_cfg.svh
// register offsets, field positions, reset values and timing counts
// assumes 5-bit management register addresses and 16-bit register data
`ifndef PHY_AUX_CFG_SVH
`define PHY_AUX_CFG_SVH
// register offsets
`define ADDR_MODE2 5'h1b
`define ADDR_ERRST 5'h1c
`define ADDR_LEDGAP 5'h1d
`define ADDR_RESULT 5'h1e
// second auxiliary mode register fields
`define M2_DRIBBLE 11
`define M2_JUMBO 10
`define M2_TXC_INV 8
`define M2_ECHO_BLK 7
`define M2_QPD 1
`define M2_RESET 16'h008a
// error and general status fields
`define ES_SWAP_ST 13
`define ES_SWAP_MAN 12
`define ES_XO_DIS 11
`define ES_MAN_ERR 10
`define ES_EOF_ERR 9
`define ES_NEG_IND 3
`define ES_FAST_SPEED_STRAP_IN_IND 2
`define ES_SPD_IND 1
`define ES_FDX_IND 0
// link led / gap guard fields
`define LG_LED_DIS 3
`define LG_BLK_TXEN 1
// negotiation result / control fields
`define RS_RES_HI 15
`define RS_RES_LO 11
`define RS_RESTART 8
`define RS_CMPL 7
`define RS_ACK_CMPL 6
`define RS_ACK_DET 5
`define RS_ABIL 4
`define RS_SISO 3
`define RS_SERIAL 1
// transmit gap guard
`define GAP_SHORT_MIN 3'h1
`define GAP_SHORT_MAX 3'h4
`define GAP_SAT 3'h7
// standard frame limit in nibbles (1518 bytes)
`define MAX_FRAME_NIB 3036
`endif

// File: phy_aux_pkg.sv
// types shared by the auxiliary register block and its helpers
// assumes phy_aux_cfg.svh supplies the numeric constants
package phy_aux_pkg;
  // negotiation progress as seen by the status bits
  typedef enum logic [2:0] {
    NG_OFF = 3'b000,
    NG_ABIL = 3'b001,
    NG_ACKD = 3'b010,
    NG_ACKC = 3'b011,
    NG_DONE = 3'b100,
    NG_PD = 3'b101
  } nego_state_t;
  // negotiated result code from the line engine
  typedef logic [2:0] res_code_t;
  typedef logic [4:0] res_bits_t;
endpackage

// File: nego_tracker.sv
// negotiation status tracker: progress bits, result bits, link and speed
// assumes event inputs are already synchronised one-cycle pulses or levels
`timescale 1ns/10ps
`default_nettype none
`include "phy_aux_cfg.svh"
module nego_tracker (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic nego_en,
  input wire logic restart,
  input wire logic flp_seen,
  input wire logic ack_seen,
  input wire logic ack_done,
  input wire logic legacy_seen,
  input wire logic legacy_fast,
  input wire phy_aux_pkg::res_code_t lp_result,
  input wire logic link_fault,
  input wire logic qpd_en,
  input wire logic adv_10,
  input wire logic adv_100,
  input wire logic forced_fast,
  input wire logic forced_fdx,
  output logic complete_r,
  output logic ack_cmpl_r,
  output logic ack_det_r,
  output logic ability_r,
  output phy_aux_pkg::res_bits_t results_r,
  output logic link_up_r,
  output logic speed_fast_r,
  output logic full_duplex_r
);
  import phy_aux_pkg::*;
  nego_state_t state_r;
  logic pd_ok;

  // one-hot result bit, fastest full duplex at the top
  function automatic res_bits_t res_onehot(input res_code_t c);
    case (c)
      3'h1: res_onehot = 5'h01;
      3'h2: res_onehot = 5'h02;
      3'h3: res_onehot = 5'h04;
      3'h4: res_onehot = 5'h08;
      3'h5: res_onehot = 5'h10;
      default: res_onehot = 5'h00;
    endcase
  endfunction

  // legacy partner accepted only if its speed is advertised when qualified
  assign pd_ok = !qpd_en || (legacy_fast ? adv_100 : adv_10);

  // progress state and status bits
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_r <= NG_OFF;
      complete_r <= 1'b0;
      ack_cmpl_r <= 1'b0;
      ack_det_r <= 1'b0;
      results_r <= 5'h00;
      link_up_r <= 1'b0;
      speed_fast_r <= 1'b0;
      full_duplex_r <= 1'b0;
    end else if (!nego_en) begin
      // forced mode: speed and duplex come from the control bits
      state_r <= NG_OFF;
      complete_r <= 1'b0;
      ack_cmpl_r <= 1'b0;
      link_up_r <= legacy_seen && !link_fault;
      speed_fast_r <= forced_fast;
      full_duplex_r <= forced_fdx;
    end else if (restart || state_r == NG_OFF) begin
      state_r <= NG_ABIL;
      complete_r <= 1'b0;
      ack_cmpl_r <= 1'b0;
      ack_det_r <= 1'b0;
      results_r <= 5'h00;
      link_up_r <= 1'b0;
      speed_fast_r <= 1'b0;
      full_duplex_r <= 1'b0;
    end else begin
      case (state_r)
        NG_ABIL, NG_PD: begin
          if (flp_seen) begin
            state_r <= NG_ACKD;
          end else if (legacy_seen && pd_ok) begin
            state_r <= NG_DONE;
            complete_r <= 1'b1;
            link_up_r <= 1'b1;
            speed_fast_r <= legacy_fast;
            results_r <= results_r | res_onehot(legacy_fast ? 3'h3 : 3'h1);
          end else if (legacy_seen) begin
            state_r <= NG_PD; // keep watching for a match
          end
        end
        NG_ACKD: begin
          if (ack_seen) begin
            state_r <= NG_ACKC;
            ack_det_r <= 1'b1;
          end
        end
        NG_ACKC: begin
          if (ack_done) begin
            state_r <= NG_DONE;
            ack_cmpl_r <= 1'b1;
            complete_r <= 1'b1;
            link_up_r <= 1'b1;
            results_r <= results_r | res_onehot(lp_result);
            speed_fast_r <= lp_result >= 3'h3;
            full_duplex_r <= lp_result == 3'h2 || lp_result == 3'h5;
          end
        end
        NG_DONE: begin
          if (link_fault) begin
            // results stay, so a renegotiation may leave two set
            state_r <= NG_ABIL;
            complete_r <= 1'b0;
            ack_cmpl_r <= 1'b0;
            link_up_r <= 1'b0;
            speed_fast_r <= 1'b0;
            full_duplex_r <= 1'b0;
          end
        end
        default: state_r <= NG_OFF;
      endcase
    end
  end

  // ability-detect bit mirrors the waiting state
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ability_r <= 1'b0;
    end else begin
      ability_r <= nego_en && (state_r == NG_ABIL || state_r == NG_PD);
    end
  end
endmodule
`default_nettype wire

// File: mii_side_path.sv
// mac-side path: echo, carrier, error, dribble trim, length cap, gap guard
// assumes inputs are synchronised to core_clk; all outputs registered
`timescale 1ns/10ps
`default_nettype none
`include "phy_aux_cfg.svh"
module mii_side_path #(
  parameter int MAX_NIB = `MAX_FRAME_NIB
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic isolate,
  input wire logic echo_block,
  input wire logic half10,
  input wire logic serial,
  input wire logic dribble_en,
  input wire logic jumbo_en,
  input wire logic txc_inv,
  input wire logic block_txen,
  input wire logic tx_en,
  input wire logic [3:0] txd,
  input wire logic rx_dv_line,
  input wire logic [3:0] rxd_line,
  input wire logic rx_partial,
  input wire logic rx_carrier,
  input wire logic err_ev,
  output logic tx_en_line_r,
  output logic [3:0] txd_line_r,
  output logic rx_dv_r,
  output logic [3:0] rxd_r,
  output logic crs_r,
  output logic rxer_r,
  output logic txc_r,
  output logic mac_oe_r
);
  logic tx_q, tx_prev, dly_sel_r, sel_now, short_gap, rx_keep, tx_keep;
  logic [4:0] p1_r, p2_r;
  logic [2:0] gap_r;
  logic [15:0] rx_cnt_r, tx_cnt_r, max_nib;
  logic txc_ph_r;

  assign max_nib = 16'(MAX_NIB);
  assign tx_q = tx_en && !isolate; // mac inputs ignored
  // gap guard: a short gap shifts the next frame two cycles late
  assign short_gap = block_txen && gap_r >= `GAP_SHORT_MIN && gap_r <= `GAP_SHORT_MAX;
  assign sel_now = (tx_q && !tx_prev) ? short_gap : dly_sel_r;
  // frames beyond the standard limit are cut unless jumbo is on
  assign rx_keep = jumbo_en || rx_cnt_r < max_nib;
  assign tx_keep = jumbo_en || tx_cnt_r < max_nib;

  // idle gap count and delay line for the gap guard
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      gap_r <= `GAP_SAT;
      tx_prev <= 1'b0;
      dly_sel_r <= 1'b0;
      p1_r <= 5'h00;
      p2_r <= 5'h00;
    end else begin
      tx_prev <= tx_q;
      dly_sel_r <= sel_now;
      p1_r <= {tx_q, txd};
      p2_r <= p1_r;
      if (tx_q) begin
        gap_r <= 3'h0;
      end else if (gap_r != `GAP_SAT) begin
        gap_r <= gap_r + 3'h1;
      end
    end
  end

  // nibble counters for the length cap
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rx_cnt_r <= 16'h0000;
      tx_cnt_r <= 16'h0000;
    end else begin
      rx_cnt_r <= !rx_dv_line ? 16'h0000 : rx_cnt_r + {15'h0000, rx_keep};
      tx_cnt_r <= !tx_q ? 16'h0000 : tx_cnt_r + {15'h0000, tx_keep};
    end
  end

  // transmit toward the line; serial mode uses lane zero only
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      tx_en_line_r <= 1'b0;
      txd_line_r <= 4'h0;
    end else begin
      tx_en_line_r <= (sel_now ? p2_r[4] : tx_q) && tx_keep;
      txd_line_r <= sel_now ? p2_r[3:0] : txd;
      if (serial) begin
        txd_line_r <= {3'h0, sel_now ? p2_r[0] : txd[0]};
      end
    end
  end

  // receive toward the mac, with echo, carrier and error indication
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rx_dv_r <= 1'b0;
      rxd_r <= 4'h0;
      crs_r <= 1'b0;
      rxer_r <= 1'b0;
    end else begin
      // trailing partial nibble dropped so the mac sees whole nibbles
      rx_dv_r <= (rx_dv_line && rx_keep && !(dribble_en && rx_partial))
        || (half10 && tx_q && !echo_block);
      rxd_r <= serial ? {3'h0, rxd_line[0]} : rxd_line;
      crs_r <= rx_carrier || (half10 && tx_q); // falls with tx enable
      rxer_r <= err_ev;
    end
  end

  // transmit clock phase and output enable of the mac-side pins
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      txc_ph_r <= 1'b0;
      txc_r <= 1'b0;
      mac_oe_r <= 1'b0;
    end else begin
      txc_ph_r <= !txc_ph_r;
      txc_r <= txc_ph_r ^ txc_inv;
      mac_oe_r <= !isolate;
    end
  end
endmodule
`default_nettype wire

// File: phy_aux_mode_status_regs.sv
// auxiliary mode and status registers of one transceiver port
// assumes a word-wide management register port on core_clk; pins are
// synchronised here before use, all but lp_result_in
`timescale 1ns/10ps
`default_nettype none
`include "phy_aux_cfg.svh"
module phy_aux_mode_status_regs #(
  parameter int MAX_NIB = `MAX_FRAME_NIB
) (
  input wire logic core_clk,
  input wire logic rst_n,
  // management register port
  input wire logic [4:0] mgmt_addr,
  input wire logic mgmt_wr,
  input wire logic mgmt_rd,
  input wire logic [15:0] mgmt_wdata,
  output logic [15:0] mgmt_rdata,
  // control and advertisement bits held elsewhere in the port
  input wire logic ctrl_nego_en_in,
  input wire logic ctrl_speed_sel_in,
  input wire logic ctrl_full_duplex_in,
  input wire logic adv_10_in,
  input wire logic adv_100_in,
  // strap pins
  input wire logic negotiation_strap_in,
  input wire logic fast_speed_strap_in,
  // line-side engine events
  input wire logic flp_seen_in,
  input wire logic ack_seen_in,
  input wire logic ack_done_in,
  input wire logic legacy_seen_in,
  input wire logic legacy_fast_in,
  input wire phy_aux_pkg::res_code_t lp_result_in,
  input wire logic link_fault_in,
  input wire logic crossover_seen_in,
  input wire logic manchester_err_in,
  input wire logic eof_err_in,
  // mac side
  input wire logic tx_en_in,
  input wire logic [3:0] txd_in,
  input wire logic rx_dv_line_in,
  input wire logic [3:0] rxd_line_in,
  input wire logic rx_partial_in,
  input wire logic rx_carrier_in,
  output logic tx_en_line_out,
  output logic [3:0] txd_line_out,
  output logic rx_dv_out,
  output logic [3:0] rxd_out,
  output logic crs_out,
  output logic rxer_out,
  output logic txc_out,
  output logic mac_out_en,
  // line and indicator controls
  output logic link_pulse_en,
  output logic pair_swap_out,
  output logic auto_xover_en_out,
  output logic link_led_on,
  output logic link_up_out
);
  import phy_aux_pkg::*;

  localparam int NPIN = 23;
  localparam logic [15:0] MODE2_RST = `M2_RESET;

  // register state
  logic dribble_r, jumbo_r, txc_inv_r, echo_blk_r, qpd_r;
  logic swap_man_r, xo_dis_r, man_err_r, eof_err_r;
  logic led_dis_r, blk_txen_r, siso_r, serial_r;
  logic restart_r;
  // synchronisers
  logic [NPIN-1:0] pin_s1, pin_s2;
  logic man_d_r, eof_d_r;
  // decoded status
  logic strap_neg, strap_fast_speed_strap_in, nego_en, forced_fast, is_10;
  logic man_ev, eof_ev, err_ev, rd_errst, swap_st;
  logic tx_en_s, rx_dv_s, rx_part_s, rx_car_s;
  logic [3:0] txd_s, rxd_s;
  logic cmpl, ack_cmpl, ack_det, ability, link_up, spd_fast, fdx;
  res_bits_t results;
  logic [15:0] rd_word;

  // address match shared by write and read decoding
  function automatic logic hit(input logic [4:0] a, input logic [4:0] reg_a);
    hit = a == reg_a;
  endfunction

  // every pin except lp_result_in passes two flops before anything looks at it
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
    end else begin
      pin_s1 <= {negotiation_strap_in, fast_speed_strap_in, manchester_err_in,
        eof_err_in, crossover_seen_in, tx_en_in, txd_in, rx_dv_line_in,
        rxd_line_in, rx_partial_in, rx_carrier_in, flp_seen_in, ack_seen_in,
        ack_done_in, legacy_seen_in, legacy_fast_in, link_fault_in};
      pin_s2 <= pin_s1;
    end
  end

  assign strap_neg = pin_s2[22];
  assign strap_fast_speed_strap_in = pin_s2[21];
  assign tx_en_s = pin_s2[17];
  assign txd_s = pin_s2[16:13];
  assign rx_dv_s = pin_s2[12];
  assign rxd_s = pin_s2[11:8];
  assign rx_part_s = pin_s2[7];
  assign rx_car_s = pin_s2[6];

  // error pin edges, taken from the second stage only
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      man_d_r <= 1'b0;
      eof_d_r <= 1'b0;
    end else begin
      man_d_r <= pin_s2[20];
      eof_d_r <= pin_s2[19];
    end
  end

  // derived mode and speed status
  assign nego_en = ctrl_nego_en_in && strap_neg;
  // forced 10 Mb when both straps low or both control bits cleared
  assign forced_fast = !((!strap_neg && !strap_fast_speed_strap_in) ||
    (!ctrl_nego_en_in && !ctrl_speed_sel_in));
  assign is_10 = !spd_fast;
  assign man_ev = pin_s2[20] && !man_d_r && is_10;
  assign eof_ev = pin_s2[19] && !eof_d_r && is_10;
  assign err_ev = man_ev || eof_ev;
  assign rd_errst = mgmt_rd && hit(mgmt_addr, `ADDR_ERRST);
  assign swap_st = swap_man_r || (!xo_dis_r && pin_s2[18]);

  // second auxiliary mode register
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      dribble_r <= MODE2_RST[`M2_DRIBBLE];
      jumbo_r <= MODE2_RST[`M2_JUMBO];
      txc_inv_r <= MODE2_RST[`M2_TXC_INV];
      echo_blk_r <= MODE2_RST[`M2_ECHO_BLK];
      qpd_r <= MODE2_RST[`M2_QPD];
    end else if (mgmt_wr && hit(mgmt_addr, `ADDR_MODE2)) begin
      dribble_r <= mgmt_wdata[`M2_DRIBBLE];
      jumbo_r <= mgmt_wdata[`M2_JUMBO];
      txc_inv_r <= mgmt_wdata[`M2_TXC_INV];
      echo_blk_r <= mgmt_wdata[`M2_ECHO_BLK];
      qpd_r <= mgmt_wdata[`M2_QPD];
    end
  end

  // crossover controls
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      swap_man_r <= 1'b0;
      xo_dis_r <= 1'b0;
    end else if (mgmt_wr && hit(mgmt_addr, `ADDR_ERRST)) begin
      swap_man_r <= mgmt_wdata[`ES_SWAP_MAN];
      xo_dis_r <= mgmt_wdata[`ES_XO_DIS];
    end
  end

  // latched error flags; a new error in the read cycle stays set
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      man_err_r <= 1'b0;
      eof_err_r <= 1'b0;
    end else begin
      man_err_r <= man_ev || (man_err_r && !rd_errst);
      eof_err_r <= eof_ev || (eof_err_r && !rd_errst);
    end
  end

  // link indicator and gap guard controls
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      led_dis_r <= 1'b0;
      blk_txen_r <= 1'b0;
    end else if (mgmt_wr && hit(mgmt_addr, `ADDR_LEDGAP)) begin
      led_dis_r <= mgmt_wdata[`LG_LED_DIS];
      blk_txen_r <= mgmt_wdata[`LG_BLK_TXEN];
    end
  end

  // isolate and serial controls; restart is a one-cycle pulse
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      siso_r <= 1'b0;
      serial_r <= 1'b0;
      restart_r <= 1'b0;
    end else begin
      // restart needs negotiation enabled; writing zero does nothing
      restart_r <= mgmt_wr && hit(mgmt_addr, `ADDR_RESULT) &&
        mgmt_wdata[`RS_RESTART] && nego_en;
      if (mgmt_wr && hit(mgmt_addr, `ADDR_RESULT)) begin
        siso_r <= mgmt_wdata[`RS_SISO];
        serial_r <= mgmt_wdata[`RS_SERIAL];
      end
    end
  end

  // read word assembly; reserved bits are zero
  always_comb begin
    rd_word = 16'h0000;
    if (hit(mgmt_addr, `ADDR_MODE2)) begin
      rd_word[`M2_DRIBBLE] = dribble_r;
      rd_word[`M2_JUMBO] = jumbo_r;
      rd_word[`M2_TXC_INV] = txc_inv_r;
      rd_word[`M2_ECHO_BLK] = echo_blk_r;
      rd_word[`M2_QPD] = qpd_r;
    end else if (hit(mgmt_addr, `ADDR_ERRST)) begin
      rd_word[`ES_SWAP_ST] = swap_st;
      rd_word[`ES_SWAP_MAN] = swap_man_r;
      rd_word[`ES_XO_DIS] = xo_dis_r;
      rd_word[`ES_MAN_ERR] = man_err_r;
      rd_word[`ES_EOF_ERR] = eof_err_r;
      rd_word[`ES_NEG_IND] = nego_en;
      rd_word[`ES_FAST_SPEED_STRAP_IN_IND] = forced_fast;
      rd_word[`ES_SPD_IND] = spd_fast;
      rd_word[`ES_FDX_IND] = fdx;
    end else if (hit(mgmt_addr, `ADDR_LEDGAP)) begin
      rd_word[`LG_LED_DIS] = led_dis_r;
      rd_word[`LG_BLK_TXEN] = blk_txen_r;
    end else if (hit(mgmt_addr, `ADDR_RESULT)) begin
      rd_word[`RS_RES_HI:`RS_RES_LO] = results;
      rd_word[`RS_CMPL] = cmpl;
      rd_word[`RS_ACK_CMPL] = ack_cmpl;
      rd_word[`RS_ACK_DET] = ack_det;
      rd_word[`RS_ABIL] = ability;
      rd_word[`RS_SISO] = siso_r;
      rd_word[`RS_SERIAL] = serial_r;
    end
  end

  // read data registered; holds between reads
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      mgmt_rdata <= 16'h0000;
    end else if (mgmt_rd) begin
      mgmt_rdata <= rd_word;
    end
  end

  // line and indicator outputs
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      link_pulse_en <= 1'b0;
      pair_swap_out <= 1'b0;
      auto_xover_en_out <= 1'b0;
      link_led_on <= 1'b0;
      link_up_out <= 1'b0;
    end else begin
      link_pulse_en <= !siso_r;
      pair_swap_out <= swap_st;
      auto_xover_en_out <= !xo_dis_r && !swap_man_r;
      link_led_on <= link_up && !led_dis_r;
      link_up_out <= link_up;
    end
  end

  nego_tracker u_nego (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .nego_en(nego_en),
    .restart(restart_r),
    .flp_seen(pin_s2[5]),
    .ack_seen(pin_s2[4]),
    .ack_done(pin_s2[3]),
    .legacy_seen(pin_s2[2]),
    .legacy_fast(pin_s2[1]),
    .lp_result(lp_result_in),
    .link_fault(pin_s2[0]),
    .qpd_en(qpd_r),
    .adv_10(adv_10_in),
    .adv_100(adv_100_in),
    .forced_fast(forced_fast),
    .forced_fdx(ctrl_full_duplex_in),
    .complete_r(cmpl),
    .ack_cmpl_r(ack_cmpl),
    .ack_det_r(ack_det),
    .ability_r(ability),
    .results_r(results),
    .link_up_r(link_up),
    .speed_fast_r(spd_fast),
    .full_duplex_r(fdx)
  );

  // serial mode is refused at 100 Mb
  mii_side_path #(
    .MAX_NIB(MAX_NIB)
  ) u_mii (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .isolate(siso_r),
    .echo_block(echo_blk_r),
    .half10(is_10 && !fdx),
    .serial(serial_r && is_10),
    .dribble_en(dribble_r),
    .jumbo_en(jumbo_r),
    .txc_inv(txc_inv_r),
    .block_txen(blk_txen_r),
    .tx_en(tx_en_s),
    .txd(txd_s),
    .rx_dv_line(rx_dv_s),
    .rxd_line(rxd_s),
    .rx_partial(rx_part_s),
    .rx_carrier(rx_car_s),
    .err_ev(err_ev),
    .tx_en_line_r(tx_en_line_out),
    .txd_line_r(txd_line_out),
    .rx_dv_r(rx_dv_out),
    .rxd_r(rxd_out),
    .crs_r(crs_out),
    .rxer_r(rxer_out),
    .txc_r(txc_out),
    .mac_oe_r(mac_out_en)
  );
endmodule
`default_nettype wire

// File: aux_chk.sv
// port checker for the auxiliary register block
// assumes it is bound into phy_aux_mode_status_regs
`timescale 1ns/10ps
`default_nettype none
`include "phy_aux_cfg.svh"
module aux_chk (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [4:0] mgmt_addr,
  input wire logic mgmt_wr,
  input wire logic mgmt_rd,
  input wire logic [15:0] mgmt_wdata,
  input wire logic [15:0] mgmt_rdata,
  input wire logic pair_swap_out,
  input wire logic auto_xover_en_out,
  input wire logic link_led_on,
  input wire logic mac_out_en,
  input wire logic link_pulse_en
);
  logic [3:0] sh_r; // isolate, led off, swap, crossover off
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // shadow of written controls, so outputs can be tied to them
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sh_r <= 4'h0;
    end else if (mgmt_wr && mgmt_addr == `ADDR_ERRST) begin
      sh_r[1:0] <= mgmt_wdata[12:11];
    end else if (mgmt_wr && mgmt_addr == `ADDR_LEDGAP) begin
      sh_r[2] <= mgmt_wdata[3];
    end else if (mgmt_wr && mgmt_addr == `ADDR_RESULT) begin
      sh_r[3] <= mgmt_wdata[3];
    end
  end
  property p_unmapped;
    mgmt_rd && (mgmt_addr < 5'h1b || mgmt_addr == 5'h1f) |=> mgmt_rdata == 16'h0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_restart_rd;
    mgmt_rd && mgmt_addr == `ADDR_RESULT |=> !mgmt_rdata[8];
  endproperty
  a_restart_rd: assert property (p_restart_rd) else $error("restart bit read one");
  property p_resv;
    mgmt_rd && mgmt_addr == `ADDR_ERRST |=> mgmt_rdata[15:14] == 2'h0 && mgmt_rdata[8:4] == 5'h00;
  endproperty
  a_resv: assert property (p_resv) else $error("reserved status bits set");
  property p_hold;
    !mgmt_rd |=> $stable(mgmt_rdata);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved without read");
  property p_swap;
    sh_r[1] && $past(sh_r[1], 3) |-> pair_swap_out;
  endproperty
  a_swap: assert property (p_swap) else $error("manual swap not applied");
  property p_xo;
    sh_r[0] && $past(sh_r[0], 3) |-> !auto_xover_en_out;
  endproperty
  a_xo: assert property (p_xo) else $error("auto crossover still on");
  property p_led;
    sh_r[2] && $past(sh_r[2], 3) |-> !link_led_on;
  endproperty
  a_led: assert property (p_led) else $error("link led on while disabled");
  property p_iso;
    sh_r[3] && $past(sh_r[3], 3) |-> !mac_out_en && !link_pulse_en;
  endproperty
  a_iso: assert property (p_iso) else $error("isolate left outputs active");
endmodule
bind phy_aux_mode_status_regs aux_chk i_chk (.core_clk, .rst_n, .mgmt_addr, .mgmt_wr,
  .mgmt_rd, .mgmt_wdata, .mgmt_rdata, .pair_swap_out, .auto_xover_en_out, .link_led_on,
  .mac_out_en, .link_pulse_en);
`default_nettype wire

// File: mac_model.sv
// mac transmit model: one frame of len nibbles per go pulse
// assumes the bench clock; drives just after the falling edge
`timescale 1ns/10ps
`default_nettype none
module mac_model (
  input wire logic core_clk,
  input wire logic go,
  input wire logic [7:0] len,
  output logic tx_en,
  output logic [3:0] txd
);
  int n = 0;
  initial tx_en = 1'b0;
  initial txd = 4'h0;
  // idle data toggles so a stale nibble is never mistaken for data
  always @(negedge core_clk) begin
    tx_en <= n > 0;
    txd <= (n > 0) ? n[3:0] : ~txd;
    n <= (go && n == 0) ? int'(len) : ((n > 0) ? n - 1 : 0);
  end
endmodule
`default_nettype wire

// File: phy_aux_mode_status_regs_test.sv
// bench for the auxiliary register block with a mac model
// assumes the checker binds itself into the block
`timescale 1ns/10ps
`default_nettype none
`include "phy_aux_cfg.svh"
module phy_aux_mode_status_regs_test;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [4:0] a = 5'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] wd = 16'h0000;
  logic [15:0] q;
  logic [18:0] ev = 19'h0_0000; // control, strap and line event pins
  logic go = 1'b0;
  logic [2:0] lpr = 3'h0;
  logic tx_en, rx_dv, crs, rxer, swp, oe, lp, te1, te2, te3;
  logic [3:0] txd;
  int bad_count = 0;
  int n_tests = 0;
  int cyc = 0;
  always #20 core_clk = ~core_clk;
  mac_model i_mac (.core_clk(core_clk), .go(go), .len(8'h06), .tx_en(tx_en), .txd(txd));
  phy_aux_mode_status_regs #(.MAX_NIB(20)) i_dut (.core_clk(core_clk), .rst_n(rst_n),
    .mgmt_addr(a), .mgmt_wr(wr), .mgmt_rd(rd), .mgmt_wdata(wd), .mgmt_rdata(q),
    .ctrl_nego_en_in(ev[0]), .ctrl_speed_sel_in(ev[1]), .ctrl_full_duplex_in(ev[2]),
    .adv_10_in(ev[3]), .adv_100_in(ev[4]), .negotiation_strap_in(ev[5]),
    .fast_speed_strap_in(ev[6]), .flp_seen_in(ev[7]), .ack_seen_in(ev[8]),
    .ack_done_in(ev[9]), .legacy_seen_in(ev[10]), .legacy_fast_in(ev[11]),
    .lp_result_in(lpr), .link_fault_in(ev[12]), .crossover_seen_in(ev[13]),
    .manchester_err_in(ev[14]), .eof_err_in(ev[15]), .tx_en_in(tx_en), .txd_in(txd),
    .rx_dv_line_in(ev[16]), .rxd_line_in(4'h0), .rx_partial_in(ev[17]),
    .rx_carrier_in(ev[18]), .tx_en_line_out(), .txd_line_out(), .rx_dv_out(rx_dv),
    .rxd_out(), .crs_out(crs), .rxer_out(rxer), .txc_out(), .mac_out_en(oe),
    .link_pulse_en(lp), .pair_swap_out(swp), .auto_xover_en_out(), .link_led_on(),
    .link_up_out());
  // tx enable history, three edges deep, to match the output latency
  always @(posedge core_clk) {te3, te2, te1} <= {te2, te1, tx_en};
  // hang guard well above the run length
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      bad_count++;
      report_and_stop();
    end
  end
  task automatic chk(input string s, input logic [15:0] e, input logic [15:0] v);
    n_tests++;
    if (v !== e) begin
      bad_count++;
      $display("[FAIL] %s exp %h got %h", s, e, v);
    end
  endtask
  task automatic wrt(input logic [4:0] ad, input logic [15:0] d);
    @(negedge core_clk);
    a = ad;
    wd = d;
    wr = 1'b1;
    @(negedge core_clk);
    wr = 1'b0;
    repeat (3) @(negedge core_clk);
  endtask
  task automatic rc(input logic [4:0] ad, input logic [15:0] e, input logic [15:0] m);
    @(negedge core_clk);
    a = ad;
    rd = 1'b1;
    @(negedge core_clk);
    rd = 1'b0;
    chk("reg", e, q & m);
  endtask
  // reset values, unmapped place, negotiation and forced indications
  task automatic t_regs();
    rc(`ADDR_MODE2, 16'h0082, 16'hffff);
    rc(`ADDR_ERRST, 16'h0000, 16'hffff);
    rc(`ADDR_RESULT, 16'h0000, 16'hffff);
    rc(5'h05, 16'h0000, 16'hffff);
    ev[5:0] = 6'h21;
    repeat (4) @(negedge core_clk);
    rc(`ADDR_ERRST, 16'h000c, 16'h000f);
    ev[5:0] = 6'h00;
    repeat (4) @(negedge core_clk);
  endtask
  // each error raises rxer, latches its flag, read clears it
  task automatic t_err();
    int s;
    for (int i = 0; i < 2; i++) begin
      s = 0;
      ev[14 + i] = 1'b1;
      repeat (3) @(negedge core_clk) s = s | rxer;
      ev[14 + i] = 1'b0;
      repeat (6) @(negedge core_clk) s = s | rxer;
      chk("rxer", 16'h0001, 16'(s));
      rc(`ADDR_ERRST, 16'h0400 >> i, 16'h0600);
      rc(`ADDR_ERRST, 16'h0000, 16'h0600);
    end
  endtask
  // manual swap, then automatic crossover
  task automatic t_swap();
    wrt(`ADDR_ERRST, 16'h1000);
    rc(`ADDR_ERRST, 16'h3000, 16'h3800);
    chk("swap", 16'h0001, {15'h0000, swp});
    ev[13] = 1'b1;
    wrt(`ADDR_ERRST, 16'h0800);
    rc(`ADDR_ERRST, 16'h0800, 16'h3800);
    wrt(`ADDR_ERRST, 16'h0000);
    rc(`ADDR_ERRST, 16'h2000, 16'h3800);
    ev[13] = 1'b0;
    wrt(`ADDR_LEDGAP, 16'h0008);
    rc(`ADDR_LEDGAP, 16'h0008, 16'hffff);
    wrt(`ADDR_LEDGAP, 16'h0000);
  endtask
  // echo blocking at 10 Mb half duplex: carrier tracks tx enable only
  task automatic t_echo();
    go <= 1'b1;
    @(negedge core_clk);
    go <= 1'b0;
    repeat (14) begin
      @(negedge core_clk);
      chk("crs", {15'h0000, te3}, {15'h0000, crs});
      chk("rxdv", 16'h0000, {15'h0000, rx_dv});
    end
  endtask
  // restart self clears; isolate floats the mac side
  task automatic t_iso();
    wrt(`ADDR_RESULT, 16'h0100);
    rc(`ADDR_RESULT, 16'h0000, 16'h0100);
    wrt(`ADDR_RESULT, 16'h0008);
    rc(`ADDR_RESULT, 16'h0008, 16'h000f);
    chk("iso", 16'h0000, {14'h0000, oe, lp});
    wrt(`ADDR_RESULT, 16'h0000);
  endtask
  // full negotiation, then restart
  task automatic t_nego();
    ev[5:0] = 6'h21;
    lpr = 3'h5;
    for (int i = 7; i < 10; i++) begin
      ev[i] = 1'b1;
      repeat (4) @(negedge core_clk);
    end
    rc(`ADDR_RESULT, 16'h80e0, 16'hffff);
    rc(`ADDR_ERRST, 16'h000f, 16'h000f);
    ev[9:7] = 3'h0;
    wrt(`ADDR_RESULT, 16'h0100);
    rc(`ADDR_RESULT, 16'h0010, 16'hffff);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(negedge core_clk);
    rst_n = 1'b1;
    repeat (3) @(negedge core_clk);
    t_regs();
    t_err();
    t_swap();
    t_echo();
    t_iso();
    t_nego();
    report_and_stop();
  end
endmodule
`default_nettype wire
